// ### rtl/clk_prescale.sv
// Power-of-two tick prescaler for the time base
`timescale 1ns/1ns
module clk_prescale
    import tb_ctl_pkg::*;
(
    input  wire logic       mclk,     // Clock
    input  wire logic       arst_n,   // Async reset, active low
    input  wire logic       run,      // Count enable
    input  wire logic [2:0] sel,      // Divide code
    output logic            tick      // One-cycle tick
);
    logic [5:0] cnt_reg;              // Divider counter
    logic [5:0] lim;                  // Terminal count

    // Terminal count is 2^sel - 1, reserved code clamps to max
    always_comb
    begin
        lim = (sel > DIV_MAX) ? 6'h3F : 6'((7'h01 << sel) - 7'h01);
    end

    assign tick = run && (cnt_reg >= lim);

    // Divider counter, cleared while stopped
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_reg <= 6'h00;
        else if (!run || tick)
            cnt_reg <= 6'h00;
        else
            cnt_reg <= cnt_reg + 6'h01;
    end

    // Divide code 0 ticks every enabled clock
    a_div_one_tick: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (run && sel == 3'h0) |-> tick)
        else $error("divide by one missed a tick");
endmodule : clk_prescale

// ### rtl/event_postscale.sv
// Postscaler for compare match events
`timescale 1ns/1ns
module event_postscale
    import tb_ctl_pkg::*;
(
    input  wire logic       mclk,     // Clock
    input  wire logic       arst_n,   // Async reset, active low
    input  wire logic       clr,      // Restart counting
    input  wire logic       match,    // Compare match pulse
    input  wire logic [3:0] ratio,    // Field value, N-1
    output logic            trig      // Trigger pulse
);
    logic [3:0] cnt_reg;              // Matches seen

    assign trig = match && (cnt_reg == ratio);

    // Count matches, wrap on trigger
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_reg <= 4'h0;
        else if (clr || trig)
            cnt_reg <= 4'h0;
        else if (match)
            cnt_reg <= cnt_reg + 4'h1;
    end

    // Ratio zero passes every match
    a_ratio_one: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (match && ratio == 4'h0 && !clr) |-> trig)
        else $error("1:1 postscale dropped a match");
endmodule : event_postscale

// ### rtl/pwm_time_base.sv
// Primary time base control with register port and interrupts
// Functional notes
// - Enable bit 15 runs the whole unit
// - Bit 13 halts time base in idle
// - Bit 12 pending set and cleared by hardware
// - Bit 11 gates the special event interrupt
// - Bit 10 immediate period load, else boundary
// - Bit 9 inverts sync input and output
// - Bit 8 enables the sync output pin
// - Bit 7 enables external sync restart
// - Source field picks sync input one-four
// - Postscaler triggers every field-plus-one match
// - Prescaler divides by two to the code, reserved code 7 by 64
// - Unimplemented bits read as zero
// - Compare uses bits 15 to 3
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module pwm_time_base
    import tb_ctl_pkg::*;
(
    input  wire logic        mclk,        // Clock, 25 MHz
    input  wire logic        arst_n,      // Async reset, active low
    input  wire logic [3:0]  addr,        // Register address
    input  wire logic [15:0] wdata,       // Write data
    input  wire logic        wr,          // Write strobe
    input  wire logic        rd,          // Read strobe
    output logic      [15:0] rdata,       // Read data, next cycle
    input  wire logic        cpu_idle,    // CPU in idle mode
    input  wire logic [3:0]  sync_input_n, // External sync inputs
    output logic             primary_sync_output, // Sync output pin
    output logic             special_event_trig,  // Trigger pulse
    output logic      [15:0] primary_time_base_counter, // Counter
    output logic             irq          // Interrupt, level
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] tbcon_reg;               // Time base control
    logic [15:0] clkdiv_reg;              // Clock divider select
    logic [15:0] period_reg;              // Written period
    logic [15:0] act_per_reg;             // Active period
    logic        per_pend_reg;            // Period awaits boundary
    logic [15:0] secmp_reg;               // Special event compare
    logic [1:0]  irq_st_reg;              // Sticky interrupt status
    logic [1:0]  irq_msk_reg;             // Interrupt mask
    logic [15:0] cnt_reg;                 // Time base counter
    logic        sync_in_reg;             // Registered sync level
    logic        sync_out_reg;            // Sync output pin
    logic [15:0] rdata_reg;               // Read data
    logic        trig_reg;                // Registered trigger

    // Control fields
    logic        module_enable;           // Unit run
    logic        stop_in_idle;            // Halt in idle
    logic        special_event_pending;   // Pending flag
    logic        special_event_irq_enable; // Interrupt enable
    logic        immediate_period_update; // Load at once
    logic        sync_polarity;           // Active-low when set
    logic        sync_output_enable;      // Drive sync output
    logic        external_sync_enable;    // Use external sync
    logic [2:0]  sync_source_select;      // Input choice
    logic [3:0]  special_event_postscale; // Postscale ratio
    logic [2:0]  input_clock_prescale;    // Divide code

    assign module_enable            = tbcon_reg[BIT_EN];
    assign stop_in_idle             = tbcon_reg[BIT_SIDL];
    assign special_event_pending    = tbcon_reg[BIT_SEPEND];
    assign special_event_irq_enable = tbcon_reg[BIT_SPECIAL_EVENT_IRQ_ENABLE];
    assign immediate_period_update  = tbcon_reg[BIT_IMMPER];
    assign sync_polarity            = tbcon_reg[BIT_SPOL];
    assign sync_output_enable       = tbcon_reg[BIT_SOEN];
    assign external_sync_enable     = tbcon_reg[BIT_SEN];
    assign sync_source_select       = tbcon_reg[SRC_HI:SRC_LO];
    assign special_event_postscale  = tbcon_reg[PS_HI:PS_LO];
    assign input_clock_prescale     = clkdiv_reg[2:0];

    ////////////////////////////////////////////////////////////////////////
    // Time base run control and events
    logic run;                            // Time base may advance
    logic tick;                           // Prescaled tick
    logic sync_sel;                       // Selected sync, active-high
    logic sync_rise;                      // External sync event
    logic wrap;                           // Counter reached period
    logic restart;                        // Counter restarts
    logic match;                          // Compare match
    logic se_trig;                        // Postscaled trigger
    logic wr_tbcon;                       // Control write
    logic wr_period;                      // Period write

    assign run = module_enable && !(stop_in_idle && cpu_idle);

    // Source decode, reserved codes select nothing
    always_comb
    begin
        case (sync_source_select)
            3'h0, 3'h1, 3'h2, 3'h3:
                sync_sel = sync_input_n[sync_source_select[1:0]]
                           ^ sync_polarity;
            default:
                sync_sel = 1'b0;
        endcase
    end

    assign sync_rise = external_sync_enable && run
                       && sync_sel && !sync_in_reg;
    assign wrap      = tick && (cnt_reg >= act_per_reg);
    assign restart   = wrap || sync_rise;
    assign match     = tick && (cnt_reg == secmp_reg);
    assign wr_tbcon  = wr && (addr == OFS_TBCON);
    assign wr_period = wr && (addr == OFS_PERIOD);

    clk_prescale u_prescale (
        .mclk   (mclk),
        .arst_n (arst_n),
        .run    (run),
        .sel    (input_clock_prescale),
        .tick   (tick)
    );

    event_postscale u_postscale (
        .mclk   (mclk),
        .arst_n (arst_n),
        .clr    (!module_enable),
        .match  (match),
        .ratio  (special_event_postscale),
        .trig   (se_trig)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sync input edge memory, pin taken as synchronous
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sync_in_reg <= 1'b0;
        else
            sync_in_reg <= sync_sel;
    end

    // Time base counter
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_reg <= 16'h0000;
        else if (!module_enable)
            cnt_reg <= 16'h0000;
        else if (restart)
            cnt_reg <= 16'h0000;
        else if (tick)
            cnt_reg <= cnt_reg + 16'h0001;
    end

    // Written period register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            period_reg <= PERIOD_RST;
        else if (wr_period)
            period_reg <= wdata;
    end

    // Active period load, immediate or at restart
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            act_per_reg  <= PERIOD_RST;
            per_pend_reg <= 1'b0;
        end
        else if (wr_period && (immediate_period_update || !module_enable))
        begin
            act_per_reg  <= wdata;
            per_pend_reg <= 1'b0;
        end
        else if (wr_period)
            per_pend_reg <= 1'b1;
        else if (per_pend_reg && (restart || !module_enable))
        begin
            act_per_reg  <= period_reg;
            per_pend_reg <= 1'b0;
        end
    end

    // Special event compare register, low bits unimplemented
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            secmp_reg <= SECMP_RST;
        else if (wr && addr == OFS_SECMP)
            secmp_reg <= wdata & SECMP_WMASK;
    end

    // Control register; pending bit set and cleared by hardware
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            tbcon_reg <= TBCON_RST;
        else
        begin
            if (wr_tbcon)
                tbcon_reg <= (wdata & TBCON_WMASK)
                             | (tbcon_reg & ~TBCON_WMASK);
            if (se_trig)
                tbcon_reg[BIT_SEPEND] <= 1'b1;
            else if (irq_st_reg[IRQ_SE] == 1'b0 || !module_enable)
                tbcon_reg[BIT_SEPEND] <= 1'b0;
        end
    end

    // Clock divider select register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            clkdiv_reg <= CLKDIV_RST;
        else if (wr && addr == OFS_CLKDIV)
            clkdiv_reg <= wdata & CLKDIV_WMASK;
    end

    // Sync output pulse at each restart
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sync_out_reg <= 1'b0;
        else
            sync_out_reg <= (sync_output_enable && restart)
                            ^ sync_polarity;
    end

    assign primary_sync_output = sync_out_reg;

    // Trigger output register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            trig_reg <= 1'b0;
        else
            trig_reg <= se_trig;
    end

    assign special_event_trig        = trig_reg;
    assign primary_time_base_counter = cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear, set wins
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_st_reg <= 2'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if ((i == IRQ_SE && se_trig && special_event_irq_enable)
                    || (i == IRQ_SYNC && sync_rise))
                    irq_st_reg[i] <= 1'b1;
                else if (wr && addr == OFS_IRQST && wdata[i])
                    irq_st_reg[i] <= 1'b0;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_msk_reg <= 2'h0;
        else if (wr && addr == OFS_IRQMSK)
            irq_msk_reg <= wdata[1:0];
    end

    assign irq = |(irq_st_reg & irq_msk_reg);

    ////////////////////////////////////////////////////////////////////////
    // Read port, data valid the cycle after the strobe
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_reg <= 16'h0000;
        else if (rd)
        begin
            case (addr)
                OFS_TBCON:  rdata_reg <= tbcon_reg;
                OFS_CLKDIV: rdata_reg <= clkdiv_reg;
                OFS_PERIOD: rdata_reg <= period_reg;
                OFS_SECMP:  rdata_reg <= secmp_reg;
                OFS_IRQST:  rdata_reg <= {14'h0000, irq_st_reg};
                OFS_IRQMSK: rdata_reg <= {14'h0000, irq_msk_reg};
                OFS_STATUS: rdata_reg <= cnt_reg;
                default:    rdata_reg <= 16'h0000;
            endcase
        end
        else
            rdata_reg <= 16'h0000;
    end

    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_disabled_holds: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !module_enable |=> cnt_reg == 16'h0000)
        else $error("counter moved while disabled");
    a_idle_halts: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (stop_in_idle && cpu_idle) |-> !tick)
        else $error("time base ticked in idle");
    a_pend_sets: assert property (
        @(posedge mclk) disable iff (!arst_n)
        se_trig |=> special_event_pending)
        else $error("pending not set on trigger");
    a_pend_clears: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !module_enable |=> !special_event_pending)
        else $error("pending kept while disabled");
    a_irq_gated: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (se_trig && !special_event_irq_enable && !irq_st_reg[IRQ_SE])
        |=> !irq_st_reg[IRQ_SE])
        else $error("disabled event raised status");
    a_imm_load: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (wr_period && immediate_period_update)
        |=> act_per_reg == $past(wdata))
        else $error("immediate period not loaded");
    a_sync_out_off: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !sync_output_enable |=> primary_sync_output == $past(sync_polarity))
        else $error("sync output driven while disabled");
    a_sync_pulse: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (sync_output_enable && restart)
        |=> primary_sync_output != $past(sync_polarity))
        else $error("sync output missed a restart pulse");
    a_sync_restart: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (sync_rise && module_enable) |=> cnt_reg == 16'h0000)
        else $error("external sync did not restart");
    a_wrap_zero: assert property (
        @(posedge mclk) disable iff (!arst_n)
        wrap |=> cnt_reg == 16'h0000 ##1 cnt_reg <= 16'h0001)
        else $error("counter did not wrap");
endmodule : pwm_time_base

// ### rtl/tb_ctl_pkg.sv
// Constants for the primary time base control block
package tb_ctl_pkg;
    // Register offsets
    localparam logic [3:0]  OFS_TBCON   = 4'h0;
    localparam logic [3:0]  OFS_CLKDIV  = 4'h2;
    localparam logic [3:0]  OFS_PERIOD  = 4'h4;
    localparam logic [3:0]  OFS_SECMP   = 4'h6;
    localparam logic [3:0]  OFS_IRQST   = 4'h8;
    localparam logic [3:0]  OFS_IRQMSK  = 4'hA;
    localparam logic [3:0]  OFS_STATUS  = 4'hC;
    // Control field positions
    localparam int BIT_EN      = 15;
    localparam int BIT_SIDL    = 13;
    localparam int BIT_SEPEND  = 12;
    localparam int BIT_SPECIAL_EVENT_IRQ_ENABLE   = 11;
    localparam int BIT_IMMPER  = 10;
    localparam int BIT_SPOL    = 9;
    localparam int BIT_SOEN    = 8;
    localparam int BIT_SEN     = 7;
    localparam int SRC_HI      = 6;
    localparam int SRC_LO      = 4;
    localparam int PS_HI       = 3;
    localparam int PS_LO       = 0;
    // Writable control bits, unimplemented bit 14 and status bit 12 masked
    localparam logic [15:0] TBCON_WMASK = 16'hAFFF;
    localparam logic [15:0] CLKDIV_WMASK = 16'h0007;
    localparam logic [15:0] SECMP_WMASK  = 16'hFFF8;
    // Reset values
    localparam logic [15:0] TBCON_RST   = 16'h0000;
    localparam logic [15:0] CLKDIV_RST  = 16'h0000;
    localparam logic [15:0] PERIOD_RST  = 16'hFFF8;
    localparam logic [15:0] SECMP_RST   = 16'h0000;
    // Highest valid divider code
    localparam logic [2:0]  DIV_MAX     = 3'h6;
    // Sync output pulse length in clock cycles
    localparam int          SYNC_PULSE  = 1;
    // Interrupt status bits
    localparam int IRQ_SE    = 0;
    localparam int IRQ_SYNC  = 1;
endpackage : tb_ctl_pkg

// ### tb/pwm_primary_time_base_control_bench.sv
// Self-checking bench for the primary time base control block
`timescale 1ns/1ns
module pwm_primary_time_base_control_bench
    import tb_ctl_pkg::*;
;
    logic        mclk = 1'b0;      // Clock
    logic        arst_n = 1'b0;    // Reset, active low
    logic [3:0]  addr = 4'h0;      // Register address
    logic [15:0] wdata = 16'h0000; // Write data
    logic        wr = 1'b0;        // Write strobe
    logic        rd = 1'b0;        // Read strobe
    logic        rd_q = 1'b0;      // Read issued last cycle
    logic        cpu_idle = 1'b0;  // CPU idle
    logic [15:0] rdata;            // Read data
    logic [3:0]  sync_n;           // Sync inputs
    logic        sync_o;           // Sync output
    logic        trig;             // Special event trigger
    logic [15:0] cnt;              // Time base counter
    logic        irq;              // Interrupt
    logic        fire = 1'b0;      // Sync pulse request
    logic [1:0]  idx = 2'h0;       // Sync input to pulse
    logic        pol = 1'b0;       // Sync polarity
    int          seen;             // Output pulses seen
    int          bad_count = 0;    // Mismatches
    int          n_compared = 0;   // Comparisons
    logic [15:0] exp_q[$];         // Expected read data
    logic [15:0] c0;               // Saved counter value
    logic [15:0] d;                // Random data

    always #20 mclk = ~mclk;

    pwm_time_base i_pwm_time_base (
        .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .cpu_idle(cpu_idle),
        .sync_input_n(sync_n), .primary_sync_output(sync_o),
        .special_event_trig(trig), .primary_time_base_counter(cnt),
        .irq(irq));
    sync_partner i_sync_partner (
        .mclk(mclk), .fire(fire), .idx(idx), .pol(pol),
        .sync_out(sync_o), .sync_in(sync_n), .seen(seen));

    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [15:0] got,
                         input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Verdict and end of run
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // One-cycle register write
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    // One-cycle register read, expected data noted for the monitor
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        exp_q.push_back(v);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask : rd_reg
    // Wait for a trigger or a counter value, bounded
    task automatic wait_ev(input logic on_trig, input logic [15:0] v);
        int k;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while ((on_trig ? trig !== 1'b1 : cnt !== v) && k < 9000);
        if (k == 9000)
            check("wait", 16'h0000, 16'h0001);
    endtask : wait_ev

    ////////////////////////////////////////////////////////////////////
    // Read data stands one cycle after the strobe
    always @(posedge mclk) rd_q <= rd;
    always @(negedge mclk)
    begin
        if (rd_q)
            check("rdata", rdata, exp_q.pop_front());
    end

    ////////////////////////////////////////////////////////////////////
    // Period change in mid-cycle; value seen just before the wrap
    task automatic per_upd(input logic imm, input logic [15:0] exp);
        logic [15:0] last;
        wr_reg(OFS_TBCON, 16'h0000);
        wr_reg(OFS_PERIOD, 16'h0040);
        wr_reg(OFS_TBCON, {5'h10, imm, 10'h000});
        wait_ev(1'b0, 16'h0005);
        wr_reg(OFS_PERIOD, 16'h0018);
        last = cnt;
        for (int k = 0; k < 200 && cnt !== 16'h0000; k++)
        begin
            last = cnt;
            @(posedge mclk);
        end
        check("period top", last, exp);
    endtask : per_upd
    // Special event spacing for one postscale value
    task automatic sev(input logic [3:0] ps, input logic ie);
        time t0;
        wr_reg(OFS_TBCON, 16'h0000);
        wr_reg(OFS_PERIOD, 16'h0010);
        wr_reg(OFS_SECMP, 16'h0008);
        wr_reg(OFS_TBCON, {4'h8, ie, 7'h00, ps});
        wait_ev(1'b1, 16'h0000);
        t0 = $time;
        wait_ev(1'b1, 16'h0000);
        check("event gap", 16'(($time - t0) / 40), 16'((ps + 1) * 17));
    endtask : sev
    // Sync output pulses over four periods of seventeen ticks
    task automatic sync_out(input logic [15:0] ctl, input int exp);
        int s0;
        wr_reg(OFS_TBCON, 16'h0000);
        pol <= ctl[9];
        wr_reg(OFS_PERIOD, 16'h0010);
        wr_reg(OFS_TBCON, ctl);
        repeat (20) @(posedge mclk);
        s0 = seen;
        repeat (68) @(posedge mclk);
        check("sync pulses", 16'(seen - s0), 16'(exp));
    endtask : sync_out
    // External sync pulse in mid-period, restart expected or not
    task automatic ext_sync(input logic [15:0] ctl, input logic [1:0] i,
                            input logic exp);
        wr_reg(OFS_TBCON, 16'h0000);
        wr_reg(OFS_PERIOD, 16'h0100);
        pol <= ctl[9];
        idx <= i;
        wr_reg(OFS_TBCON, ctl);
        wait_ev(1'b0, 16'h0020);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (6) @(posedge mclk);
        check("sync restart", 16'(cnt < 16'h0010), 16'(exp));
    endtask : ext_sync

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(52));
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (20) @(posedge mclk);
        check("disabled count", cnt, 16'h0000);
        rd_reg(OFS_TBCON, TBCON_RST);
        rd_reg(OFS_CLKDIV, 16'h0000);
        rd_reg(OFS_PERIOD, 16'hFFF8);
        rd_reg(OFS_SECMP, 16'h0000);
        rd_reg(4'hE, 16'h0000);
        wr_reg(OFS_TBCON, 16'h7FFF);
        rd_reg(OFS_TBCON, 16'h2FFF);
        wr_reg(OFS_CLKDIV, 16'hFFFF);
        rd_reg(OFS_CLKDIV, 16'h0007);
        repeat (4)
        begin
            d = 16'($urandom);
            wr_reg(OFS_SECMP, d);
            rd_reg(OFS_SECMP, d & 16'hFFF8);
            wr_reg(4'hE, ~d);
            rd_reg(4'hE, 16'h0000);
        end
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(OFS_TBCON, 16'h0000);
            wr_reg(OFS_CLKDIV, 16'(c));
            wr_reg(OFS_TBCON, 16'h8000);
            wait_ev(1'b0, 16'h0003);
            c0 = 16'($time / 40);
            wait_ev(1'b0, 16'h0004);
            check("tick gap", 16'($time / 40) - c0,
                  16'h0001 << ((c == 7) ? 6 : c));
        end
        wr_reg(OFS_TBCON, 16'h0000);
        wr_reg(OFS_CLKDIV, 16'h0000);
        cpu_idle <= 1'b1;
        wr_reg(OFS_TBCON, 16'hA000);
        repeat (2) @(posedge mclk);
        c0 = cnt;
        repeat (10) @(posedge mclk);
        check("idle halt", cnt, c0);
        wr_reg(OFS_TBCON, 16'h8000);
        c0 = cnt;
        repeat (10) @(posedge mclk);
        check("idle run", 16'(cnt !== c0), 16'h0001);
        cpu_idle <= 1'b0;
        wr_reg(OFS_TBCON, 16'h0000);
        repeat (3) @(posedge mclk);
        c0 = cnt;
        repeat (10) @(posedge mclk);
        check("disabled halt", cnt, c0);
        per_upd(1'b1, 16'h0018);
        per_upd(1'b0, 16'h0040);
        wr_reg(OFS_IRQMSK, 16'h0001);
        sev(4'h0, 1'b1);
        sev(4'h1, 1'b1);
        sev(4'hF, 1'b1);
        repeat (2) @(posedge mclk);
        check("irq set", 16'(irq), 16'h0001);
        rd_reg(OFS_TBCON, 16'h980F);
        wr_reg(OFS_TBCON, 16'h0000);
        rd_reg(OFS_TBCON, 16'h0000);
        rd_reg(OFS_IRQST, 16'h0001);
        wr_reg(OFS_IRQMSK, 16'h0000);
        @(negedge mclk);
        check("irq masked", 16'(irq), 16'h0000);
        wr_reg(OFS_IRQMSK, 16'h0001);
        @(negedge mclk);
        check("irq unmasked", 16'(irq), 16'h0001);
        wr_reg(OFS_IRQST, 16'h0001);
        rd_reg(OFS_IRQST, 16'h0000);
        check("irq cleared", 16'(irq), 16'h0000);
        sev(4'h0, 1'b0);
        check("irq off", 16'(irq), 16'h0000);
        sync_out(16'h8100, 4);
        sync_out(16'h8300, 4);
        sync_out(16'h8000, 0);
        sync_out(16'h8200, 0);
        for (int i = 0; i < 4; i++)
            ext_sync(16'h8080 | 16'(i << 4) | ((i == 3) ? 16'h0200 : 16'h0),
                     2'(i), 1'b1);
        ext_sync(16'h8000, 2'h0, 1'b0);
        ext_sync(16'h80C0, 2'h0, 1'b0);
        ext_sync(16'h8080, 2'h1, 1'b0);
        wr_reg(OFS_TBCON, 16'h0000);
        repeat (4) @(posedge mclk);
        finish_test();
    end
    // Watchdog against a hang
    initial
    begin
        #(40 * 90000);
        bad_count++;
        finish_test();
    end
endmodule : pwm_primary_time_base_control_bench

// ### tb/sync_partner.sv
// Model of the external sync source and the sync output consumer
`timescale 1ns/1ns
module sync_partner
(
    input  wire logic       mclk,     // Clock
    input  wire logic       fire,     // Request one sync pulse
    input  wire logic [1:0] idx,      // Sync input to pulse
    input  wire logic       pol,      // One makes sync active low
    input  wire logic       sync_out, // Sync output of the design
    output logic      [3:0] sync_in,  // Sync inputs to the design
    output int              seen      // Active output edges seen
);
    logic [1:0] hold = 2'h0; // Active cycles left
    logic       last = 1'b0; // Output level one cycle ago
    initial seen = 0;
    ////////////////////////////////////////////////////////////////////
    // Pulse length counter, two cycles per request
    always_ff @(posedge mclk)
    begin
        if (fire)
            hold <= 2'h2;
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
    end
    // Idle lines rest at the inactive level of the polarity
    always_comb
    begin
        sync_in = {4{pol}};
        if (hold != 2'h0)
            sync_in[idx] = ~pol;
    end
    ////////////////////////////////////////////////////////////////////
    // Count edges into the active level of the sync output
    always @(posedge mclk)
    begin
        last <= sync_out;
        if (last == pol && sync_out == ~pol)
            seen <= seen + 1;
    end
endmodule : sync_partner
